//--- logic/ldc_defs.svh
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH

// ----------------------------------------
// Frame format
// ----------------------------------------
`define LDC_FRAME_BITS 16
`define LDC_MIN_BITS 7'h10
`define LDC_CNT_MAX 7'h7F
`define LDC_REPLY_REG_MSB 1'b1
`define LDC_DIAG_MSB 1'b0

// ----------------------------------------
// Bank 0 register addresses
// ----------------------------------------
`define LDC_ADDR_MAP 16'h9669
`define LDC_A_ADIM 4'h0
`define LDC_A_CAL 4'h3
`define LDC_A_SWT 4'h5
`define LDC_A_DEV 4'h6
`define LDC_A_MFS 4'h9
`define LDC_A_MON 4'hC

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define LDC_BIT_START 5
`define LDC_BIT_DONE 4
`define LDC_BIT_OVLAT 4
`define LDC_BIT_ENCAL 3
`define LDC_BIT_CLEAR_LATCHES_COMMAND 2
`define LDC_BIT_SOFT_RESET_COMMAND 1
`define LDC_BIT_IDLE 0
`define LDC_BIT_DIAGREQ 0
`define LDC_ADIM_RST 8'hF0
`define LDC_REG_RST 8'h00

`endif

//--- logic/ldc_pkg.sv
package ldc_pkg;

  typedef struct packed {
    logic wr;
    logic bank_select_bit;
    logic [5:0] addr;
    logic [7:0] data;
  } ldc_frame_t;

  typedef struct packed {
    logic in_ov;
    logic out_ov;
    logic gate_uv;
    logic open_load;
    logic short_load;
    logic over_temp;
  } ldc_fault_t;

  typedef struct packed {
    logic [1:0] op_state;
    logic temp_warn;
    logic boot_uv;
  } ldc_status_t;

  typedef struct packed {
    logic undervoltage_reset_flag;
    logic softreset_flag;
    logic transfer_error_flag;
    logic input_overvoltage_flag;
    logic output_overvoltage_flag;
    logic gate_supply_undervolt_flag;
    logic open_load_flag;
    logic shorted_load_flag;
    logic thermal_shutdown_flag;
  } ldc_latch_t;

  typedef enum logic {
    LDC_REPLY_DIAG,
    LDC_REPLY_REG
  } ldc_reply_t;

endpackage

//--- logic/ldc_sync.sv
`timescale 1ns/1ps

// ----------------------------------------
// Two-stage synchroniser per bit
// ----------------------------------------
module ldc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          meta[i] <= RST[i];
          q[i] <= RST[i];
        end else begin
          meta[i] <= d[i];
          q[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

//--- logic/ldc_spi_diag.sv
`timescale 1ns/1ps
`include "ldc_defs.svh"


module ldc_spi_diag (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic chip_select_n,
  input wire logic uv_reset_in,
  input wire ldc_pkg::ldc_fault_t fault_ev,
  input wire ldc_pkg::ldc_status_t status,
  input wire logic cal_ok,
  input wire logic mfs_ok,
  input wire logic mon_ok,
  output logic sdo,
  output logic sdo_oe_n,
  output logic cal_start,
  output logic mfs_start,
  output logic mon_start,
  output logic clear_latches_pulse,
  output logic soft_reset_pulse,
  output logic ov_latch_en,
  output logic idle_req,
  output logic cal_enable
);
  import ldc_pkg::*;

  // ----------------------------------------
  // Pin synchronisation and edges
  // ----------------------------------------
  logic [3:0] sync_q;
  logic cs_n_d;
  logic sclk_d;

  ldc_sync #(
    .W(4),
    .RST(4'h8)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({chip_select_n, sclk, sdi, uv_reset_in}),
    .q(sync_q)
  );

  wire cs_n_s = sync_q[3];
  wire sclk_s = sync_q[2];
  wire sdi_s = sync_q[1];
  wire uv_s = sync_q[0];

  wire cs_fall = cs_n_d & ~cs_n_s;
  wire cs_rise = ~cs_n_d & cs_n_s;
  wire sclk_fall = ~cs_n_s & sclk_d & ~sclk_s;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  logic [15:0] rx;
  logic [15:0] tx;
  logic [6:0] bit_cnt;
  ldc_reply_t reply_kind;
  logic [14:0] rd_reply;
  logic sent_diag;
  ldc_latch_t snap;
  ldc_latch_t latch;
  logic [2:0] done;
  logic [7:0] reg_mem [0:15];

  ldc_frame_t fr;
  assign fr = rx;

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  logic [15:0] addr_map;
  assign addr_map = `LDC_ADDR_MAP;

  wire [3:0] idx = fr.addr[3:0];
  wire [6:0] next_cnt = (bit_cnt == `LDC_CNT_MAX) ? bit_cnt : bit_cnt + 7'h01;

  wire frame_ok = (bit_cnt >= `LDC_MIN_BITS) && (bit_cnt[2:0] == 3'h0) &&
                  (bit_cnt != `LDC_CNT_MAX);
  wire addr_ok = ~fr.bank_select_bit && (fr.addr[5:4] == 2'h0) &&
                 addr_map[idx];
  wire diag_req = ~fr.wr && fr.data[`LDC_BIT_DIAGREQ];
  wire end_ok = cs_rise && frame_ok;
  wire do_write = end_ok && fr.wr && addr_ok;
  wire do_read = end_ok && ~fr.wr && ~diag_req && addr_ok;

  wire is_cal = (idx == `LDC_A_CAL);
  wire is_mfs = (idx == `LDC_A_MFS);
  wire is_mon = (idx == `LDC_A_MON);
  wire is_dev = (idx == `LDC_A_DEV);
  wire is_routine = is_cal | is_mfs | is_mon;

  wire start_wr = do_write && is_routine && fr.data[`LDC_BIT_START];
  wire [2:0] start_vec = {start_wr & is_mon, start_wr & is_mfs, start_wr & is_cal};
  wire clear_latches_command_cmd = do_write && is_dev && fr.data[`LDC_BIT_CLEAR_LATCHES_COMMAND];
  wire soft_reset_command_cmd = do_write && is_dev && fr.data[`LDC_BIT_SOFT_RESET_COMMAND];

  // Start and one-shot command bits are not stored
  wire [7:0] nostore_routine = (8'h01 << `LDC_BIT_START) | (8'h01 << `LDC_BIT_DONE);
  wire [7:0] nostore_dev = (8'h01 << `LDC_BIT_CLEAR_LATCHES_COMMAND) | (8'h01 << `LDC_BIT_SOFT_RESET_COMMAND);
  wire [7:0] nostore = is_routine ? nostore_routine : (is_dev ? nostore_dev : 8'h00);
  wire [7:0] wr_data = fr.data & ~nostore;

  // ----------------------------------------
  // Register read view
  // ----------------------------------------
  wire done_sel = (is_cal & done[0]) | (is_mfs & done[1]) | (is_mon & done[2]);
  wire [7:0] done_ovl = is_routine ? {3'h0, done_sel, 4'h0} : 8'h00;
  wire [7:0] rd_view = reg_mem[idx] | done_ovl;

  // ----------------------------------------
  // Diagnosis word
  // ----------------------------------------
  logic [15:0] diag_word;
  assign diag_word = {
    `LDC_DIAG_MSB,
    latch.softreset_flag | status.boot_uv,
    latch.undervoltage_reset_flag,
    status.op_state,
    latch.transfer_error_flag,
    done[2],
    done[1],
    done[0],
    latch.input_overvoltage_flag,
    latch.output_overvoltage_flag,
    latch.gate_supply_undervolt_flag,
    latch.open_load_flag,
    latch.shorted_load_flag,
    latch.thermal_shutdown_flag,
    status.temp_warn
  };

  // ----------------------------------------
  // Latched flag update
  // ----------------------------------------
  ldc_latch_t ev;
  ldc_latch_t read_mask;
  ldc_latch_t clr_bits;
  ldc_latch_t next_latch;

  assign ev = '{
    undervoltage_reset_flag: uv_s,
    softreset_flag: soft_reset_command_cmd,
    transfer_error_flag: cs_rise & ~frame_ok,
    input_overvoltage_flag: fault_ev.in_ov,
    output_overvoltage_flag: fault_ev.out_ov,
    gate_supply_undervolt_flag: fault_ev.gate_uv,
    open_load_flag: fault_ev.open_load,
    shorted_load_flag: fault_ev.short_load,
    thermal_shutdown_flag: fault_ev.over_temp
  };

  // Readout never clears thermal flag, nor output overvoltage when latched
  assign read_mask = '{
    undervoltage_reset_flag: 1'b1,
    softreset_flag: 1'b1,
    transfer_error_flag: 1'b1,
    input_overvoltage_flag: 1'b1,
    output_overvoltage_flag: ~ov_latch_en,
    gate_supply_undervolt_flag: 1'b1,
    open_load_flag: 1'b1,
    shorted_load_flag: 1'b1,
    thermal_shutdown_flag: 1'b0
  };

  wire diag_read_done = end_ok && sent_diag;

  // Readout clears only bits that were shown, clear command clears all; new events win
  assign clr_bits = clear_latches_command_cmd ? '1 :
                    (diag_read_done ? (snap & read_mask) : '0);
  assign next_latch = (latch & ~clr_bits) | ev;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch <= '0;
      latch.undervoltage_reset_flag <= 1'b1;
    end else begin
      latch <= next_latch;
    end
  end

  // ----------------------------------------
  // Routine completion mirrors
  // ----------------------------------------
  wire [2:0] ok_vec = {mon_ok, mfs_ok, cal_ok};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done <= 3'h0;
    end else begin
      done <= (done & ~start_vec) | ok_vec;
    end
  end

  // ----------------------------------------
  // Bank 0 register storage
  // ----------------------------------------
  genvar r;
  generate
    for (r = 0; r < 16; r++) begin : g_reg
      localparam logic [7:0] RV = (r == `LDC_A_ADIM) ? `LDC_ADIM_RST : `LDC_REG_RST;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          reg_mem[r] <= RV;
        end else if (do_write && (idx == 4'(r))) begin
          reg_mem[r] <= wr_data;
        end
      end
    end
  endgenerate

  assign ov_latch_en = reg_mem[`LDC_A_SWT][`LDC_BIT_OVLAT];
  assign idle_req = reg_mem[`LDC_A_DEV][`LDC_BIT_IDLE];
  assign cal_enable = reg_mem[`LDC_A_DEV][`LDC_BIT_ENCAL];

  // ----------------------------------------
  // Command pulses
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cal_start <= 1'b0;
      mfs_start <= 1'b0;
      mon_start <= 1'b0;
      clear_latches_pulse <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      cal_start <= start_vec[0];
      mfs_start <= start_vec[1];
      mon_start <= start_vec[2];
      clear_latches_pulse <= clear_latches_command_cmd;
      soft_reset_pulse <= soft_reset_command_cmd;
    end
  end

  // ----------------------------------------
  // Receive side
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx <= 16'h0000;
      bit_cnt <= 7'h00;
    end else if (cs_fall) begin
      bit_cnt <= 7'h00;
    end else if (sclk_fall) begin
      rx <= {rx[14:0], sdi_s};
      bit_cnt <= next_cnt;
    end
  end

  // ----------------------------------------
  // Reply selection for next frame
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reply_kind <= LDC_REPLY_DIAG;
      rd_reply <= 15'h0000;
    end else if (uv_s) begin
      reply_kind <= LDC_REPLY_DIAG;
    end else if (cs_rise) begin
      if (do_read) begin
        reply_kind <= LDC_REPLY_REG;
        rd_reply <= {fr.bank_select_bit, fr.addr, rd_view};
      end else begin
        reply_kind <= LDC_REPLY_DIAG;
      end
    end
  end

  // ----------------------------------------
  // Transmit side
  // ----------------------------------------
  wire [15:0] reply_word = (reply_kind == LDC_REPLY_REG) ?
                           {`LDC_REPLY_REG_MSB, rd_reply} : diag_word;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx <= 16'h0000;
      sent_diag <= 1'b0;
      snap <= '0;
    end else if (cs_fall) begin
      tx <= reply_word;
      sent_diag <= (reply_kind == LDC_REPLY_DIAG);
      snap <= latch;
    end else if (sclk_fall) begin
      tx <= {tx[14:0], 1'b0};
    end
  end

  // ----------------------------------------
  // Serial output pin
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= cs_n_s;
    end
  end

  assign sdo = tx[15];

endmodule

//--- testbench/ldc_spi_diag_asserts.sv
`timescale 1ns/1ps

module ldc_spi_diag_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic cal_start,
  input wire logic mfs_start,
  input wire logic mon_start,
  input wire logic clear_latches_pulse,
  input wire logic soft_reset_pulse,
  input wire logic ov_latch_en,
  input wire logic idle_req,
  input wire logic cal_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  wire any_start = cal_start | mfs_start | mon_start;
  wire [2:0] cfg_now = {ov_latch_en, idle_req, cal_enable};

  oe_enable_a: assert property ($fell(chip_select_n) |-> ##[2:5] !sdo_oe_n)
    else $error("serial output not enabled after select");
  oe_idle_a: assert property (chip_select_n [*6] |-> sdo_oe_n)
    else $error("serial output driven while deselected");
  oe_hold_a: assert property ((!chip_select_n) [*6] |-> !sdo_oe_n)
    else $error("serial output released inside frame");
  sdo_hold_a: assert property ((!chip_select_n && sclk) [*6] |-> $stable(sdo))
    else $error("serial output moved while clock high");
  clr_pulse_a: assert property (clear_latches_pulse |->
    chip_select_n ##1 !clear_latches_pulse)
    else $error("clear pulse malformed");
  soft_reset_command_pulse_a: assert property ($rose(soft_reset_pulse) |=> $fell(soft_reset_pulse))
    else $error("soft reset pulse too long");
  start_pulse_a: assert property (any_start |-> chip_select_n ##1 !any_start)
    else $error("start pulse malformed");
  cfg_frame_a: assert property ($changed(cfg_now) |->
    chip_select_n && $past(chip_select_n, 2))
    else $error("config changed inside frame");

  cover property ($rose(clear_latches_pulse));
  cover property (mon_start);
  cover property ($rose(ov_latch_en));
endmodule

bind ldc_spi_diag ldc_spi_diag_asserts ldc_spi_diag_asserts_i (.clk(clk), .resetn(resetn),
  .sclk(sclk), .chip_select_n(chip_select_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
  .cal_start(cal_start), .mfs_start(mfs_start), .mon_start(mon_start),
  .clear_latches_pulse(clear_latches_pulse), .soft_reset_pulse(soft_reset_pulse),
  .ov_latch_en(ov_latch_en), .idle_req(idle_req), .cal_enable(cal_enable));

//--- testbench/ldc_host.sv
`timescale 1ns/1ps

module ldc_host (
  input wire logic clk,
  output logic sclk,
  output logic sdi,
  output logic chip_select_n,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    chip_select_n = 1'b1;
  end
  // ----------------------------------------
  // Frame: data out on rise, sample on fall
  // ----------------------------------------
  // Low phase alternates 6 and 7 clocks for a 125 ns mean period
  task automatic xfer(input logic [31:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk);
    chip_select_n <= 1'b0;
    repeat (20) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b1;
      sdi <= w[i];
      repeat (6) @(posedge clk);
      if (n - 1 - i < 16) begin
        r = {r[14:0], sdo_oe_n ? ~sdo : sdo};
      end
      sclk <= 1'b0;
      repeat (6 + (i % 2)) @(posedge clk);
    end
    repeat (20) @(posedge clk);
    chip_select_n <= 1'b1;
    sdi <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
endmodule

//--- testbench/spi_frame_and_diag_status_test.sv
`timescale 1ns/1ps

module spi_frame_and_diag_status_test;
  import ldc_pkg::*;
  logic clk, resetn, uv_reset_in, cal_ok, mfs_ok, mon_ok;
  ldc_fault_t fault_ev;
  ldc_status_t status;
  logic sclk, sdi, chip_select_n, sdo, sdo_oe_n, cal_start, mfs_start, mon_start;
  logic clear_latches_pulse, soft_reset_pulse, ov_latch_en, idle_req, cal_enable;
  logic [15:0] rx;
  logic [15:0] n_start = 16'h0000;
  logic [15:0] n_clr = 16'h0000;
  logic [15:0] n_soft_reset_command = 16'h0000;
  int n_mismatch = 0;
  int tests_run = 0;

  ldc_spi_diag ldc_spi_diag_i (.clk(clk), .resetn(resetn), .sclk(sclk), .sdi(sdi),
    .chip_select_n(chip_select_n), .uv_reset_in(uv_reset_in), .fault_ev(fault_ev),
    .status(status), .cal_ok(cal_ok), .mfs_ok(mfs_ok), .mon_ok(mon_ok), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .cal_start(cal_start), .mfs_start(mfs_start),
    .mon_start(mon_start), .clear_latches_pulse(clear_latches_pulse),
    .soft_reset_pulse(soft_reset_pulse), .ov_latch_en(ov_latch_en),
    .idle_req(idle_req), .cal_enable(cal_enable));
  ldc_host ldc_host_i (.clk(clk), .sclk(sclk), .sdi(sdi), .chip_select_n(chip_select_n),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  wire any_start_w = cal_start | mfs_start | mon_start;
  always @(posedge clk) begin
    n_start <= n_start + {15'h0000, any_start_w};
    n_clr <= n_clr + {15'h0000, clear_latches_pulse};
    n_soft_reset_command <= n_soft_reset_command + {15'h0000, soft_reset_pulse};
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic tx(input logic [31:0] w, input int n = 16);
    ldc_host_i.xfer(w, n, rx);
  endtask
  // Previous frame must not be a register read; this frame's reply is the word
  task automatic diag(input logic [15:0] exp);
    tx(32'h0001);
    chk(rx, exp);
  endtask
  task automatic pulse(input ldc_fault_t f, input logic [2:0] ok);
    @(posedge clk);
    fault_ev <= f;
    {cal_ok, mfs_ok, mon_ok} <= ok;
    @(posedge clk);
    fault_ev <= '0;
    {cal_ok, mfs_ok, mon_ok} <= 3'h0;
  endtask
  task automatic results;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    tx(32'h0001);
    chk(rx, 16'h3000);
    diag(16'h1000);
  endtask
  task automatic t_regs;
    tx(32'h8534);
    tx(32'h0500);
    tx(32'h0001);
    chk(rx, 16'h8534);
    chk1(ov_latch_en, 1'b1);
    tx(32'h8609);
    chk1(idle_req, 1'b1);
    chk1(cal_enable, 1'b1);
    tx(32'h0600);
    tx(32'h8600);
    chk(rx, 16'h8609);
    chk1(idle_req, 1'b0);
    chk1(cal_enable, 1'b0);
  endtask
  task automatic t_unmapped;
    tx(32'h8155);
    tx(32'hC555);
    tx(32'h0100);
    tx(32'h0500);
    chk(rx, 16'h1000);
    tx(32'h0001);
    chk(rx, 16'h8534);
  endtask
  task automatic t_error;
    tx(32'h0500, 12);
    tx(32'h0001);
    chk(rx, 16'h1400);
    tx(32'h0001);
    tx(32'h000001, 24);
    tx(32'h0001);
    chk(rx, 16'h1000);
  endtask
  task automatic t_faults;
    pulse(6'h3F, 3'h0);
    diag(16'h107E);
    diag(16'h1022);
    tx(32'h8604);
    chk(n_clr, 16'h0001);
    diag(16'h1000);
    tx(32'h8524);
    pulse(6'h10, 3'h0);
    diag(16'h1020);
    diag(16'h1000);
  endtask
  task automatic t_routines;
    pulse(6'h00, 3'h7);
    diag(16'h1380);
    diag(16'h1380);
    tx(32'h8320);
    tx(32'h8920);
    tx(32'h8C20);
    chk(n_start, 16'h0003);
    diag(16'h1000);
  endtask
  task automatic t_status;
    @(posedge clk);
    status <= 4'hF;
    diag(16'h5801);
    diag(16'h5801);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      status <= {2'(s), 2'b00};
      diag({3'h0, 2'(s), 11'h000});
    end
    @(posedge clk);
    status <= 4'h8;
  endtask
  task automatic t_uv;
    tx(32'h0500);
    @(posedge clk);
    uv_reset_in <= 1'b1;
    repeat (10) @(posedge clk);
    uv_reset_in <= 1'b0;
    repeat (10) @(posedge clk);
    tx(32'h0001);
    chk(rx, 16'h3000);
    diag(16'h1000);
  endtask
  task automatic t_soft_reset_command;
    tx(32'h8602);
    chk(n_soft_reset_command, 16'h0001);
    diag(16'h5000);
    diag(16'h1000);
  endtask

  initial begin
    resetn = 1'b0;
    uv_reset_in = 1'b0;
    {cal_ok, mfs_ok, mon_ok} = 3'h0;
    fault_ev = '0;
    status = 4'h8;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    t_reset();
    t_regs();
    t_unmapped();
    t_error();
    t_faults();
    t_routines();
    t_status();
    t_uv();
    t_soft_reset_command();
    results();
  end
  initial begin
    #800000;
    n_mismatch++;
    results();
  end
endmodule
